// File: src/crc_pkg.sv
package crc_pkg;
  // Geometry of the block.
  localparam int CRC_THREADS = 2;
  localparam int CRC_TID_W = 1;
  localparam int CRC_CLS_W = 4;
  localparam int CRC_CAT_CLASSES = 16;
  localparam int CRC_MASK_W = 16;
  localparam int CRC_MIDX_W = 4;
  localparam int CRC_THR_CLASSES = 8;
  localparam int CRC_DELAY_W = 16;
  localparam int CRC_RATE_W = 8;
  // Reset values.
  localparam logic [CRC_MASK_W-1:0] CRC_MASK_RESET = 16'hffff;
  localparam logic [CRC_CLS_W-1:0] CRC_CLASS_RESET = 4'h0;
  localparam logic [CRC_DELAY_W-1:0] CRC_DELAY_RESET = 16'h0000;
  // Identification query leaves, subleaves and field positions.
  localparam logic [31:0] CRC_LEAF_FEAT = 32'h00000007;
  localparam logic [31:0] CRC_LEAF_RES = 32'h00000010;
  localparam logic [31:0] CRC_SUB_ZERO = 32'h00000000;
  localparam int CRC_FEAT_FLAG_BIT = 15;
  localparam int CRC_THR_RES_BIT = 3;
  localparam logic [31:0] CRC_SUB_THR = 32'h00000003;
  localparam int CRC_LINEAR_BIT = 2;
  // Throttle capabilities; the maximum throttle value is 90 percent.
  localparam logic [11:0] CRC_THR_MAX_M1 = 12'h059;
  localparam logic CRC_THR_LINEAR = 1'b1;
  localparam logic [CRC_DELAY_W-1:0] CRC_THR_MAX = 16'h005a;
  localparam logic [CRC_DELAY_W-1:0] CRC_PERCENT = 16'h0064;
  localparam logic [15:0] CRC_THR_CLS_M1 = 16'h0007;
  localparam logic [15:0] CRC_CAT_CLS_M1 = 16'h000f;
endpackage

// File: src/crc_top.sv
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Thread class survives deep core idle.
// [RQ2] Capacity masks survive package idle states.
// [RQ3] Power-gated cache portion ignores capacity masks.
// [RQ4] Fills after wakeup follow capacity masks.
// [RQ5] Management interrupt leaves class and masks unchanged.
// [RQ6] Without split, class maps one mask.
// [RQ7] With split, two interleaved masks per class.
// [RQ8] One class register serves all features.
// [RQ9] Per-core rate limiter throttles outgoing requests.
// [RQ10] Feature leaf reports shared control bit 15.
// [RQ11] Resource leaf bit 3 reports throttle.
// [RQ12] Throttle subleaf word A: max minus one.
// [RQ13] Word C bit 2 reports linear delays.
// [RQ14] Word D: throttle class count minus one.
// [RQ15] Classes above throttle range get no throttling.
// [RQ16] Class zero supports every feature.
// [RQ17] Masks are placement hints, not coherency.
// [RQ18] Software may disable cache shrink for determinism; this block has no such control.
// [RQ19] Management handler may reserve its own class.
// [RQ20] Split data mask at n<<1, code next.
// [RQ21] Reset: split off, masks ones, class zero.
// [RQ22] Fill carries requesting thread's class number.
// [RQ23] Core limiter uses largest thread delay.
module crc_top
  import crc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic assoc_we,
  input wire logic [CRC_TID_W-1:0] assoc_tid,
  input wire logic [CRC_CLS_W-1:0] assoc_wdata,
  input wire logic mask_we,
  input wire logic [CRC_MIDX_W-1:0] mask_idx,
  input wire logic [CRC_MASK_W-1:0] mask_wdata,
  input wire logic delay_we,
  input wire logic [CRC_CLS_W-1:0] delay_idx,
  input wire logic [CRC_DELAY_W-1:0] delay_wdata,
  input wire logic split_we,
  input wire logic split_wdata,
  input wire logic [CRC_THREADS-1:0] thread_active,
  input wire logic [CRC_MASK_W-1:0] cache_power_on,
  input wire logic fill_req,
  input wire logic [CRC_TID_W-1:0] fill_tid,
  input wire logic fill_is_code,
  input wire logic core_req_valid,
  input wire logic query_req,
  input wire logic [31:0] query_leaf,
  input wire logic [31:0] query_subleaf,
  output logic code_data_split,
  output logic [CRC_CLS_W-1:0] class_rd0,
  output logic [CRC_CLS_W-1:0] class_rd1,
  output logic fill_valid,
  output logic [CRC_CLS_W-1:0] fill_class,
  output logic [CRC_MASK_W-1:0] fill_way_mask,
  output logic [CRC_DELAY_W-1:0] core_delay,
  output logic core_req_grant,
  output logic query_valid,
  output logic [31:0] result_word_a,
  output logic [31:0] result_word_b,
  output logic [31:0] result_word_c,
  output logic [31:0] result_word_d
);

  // ==========================================================
  // Configuration state
  // ==========================================================
  // No idle-state or management-interrupt input touches this state, so it
  // simply holds through them; only reset and explicit writes change it.
  logic [CRC_CLS_W-1:0] thread_class_assoc_reg [CRC_THREADS]; // [RQ1] [RQ5]
  logic [CRC_MASK_W-1:0] cap_mask [CRC_CAT_CLASSES]; // [RQ2] [RQ5]
  logic [CRC_DELAY_W-1:0] thr_delay [CRC_THR_CLASSES];
  logic split_en;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      split_en <= 1'b0; // [RQ21]
    else if (split_we)
      split_en <= split_wdata;
  end

  genvar gi;
  generate
    for (gi = 0; gi < CRC_THREADS; gi++)
    begin : g_thr
      // One register per thread selects the class for every feature.
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          thread_class_assoc_reg[gi] <= CRC_CLASS_RESET; // [RQ21]
        else if (assoc_we && assoc_tid == CRC_TID_W'(gi))
          thread_class_assoc_reg[gi] <= assoc_wdata; // [RQ8]
      end
    end
    for (gi = 0; gi < CRC_CAT_CLASSES; gi++)
    begin : g_mask
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          cap_mask[gi] <= CRC_MASK_RESET; // [RQ21]
        else if (mask_we && mask_idx == CRC_MIDX_W'(gi))
          cap_mask[gi] <= mask_wdata;
      end
    end
    for (gi = 0; gi < CRC_THR_CLASSES; gi++)
    begin : g_delay
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          thr_delay[gi] <= CRC_DELAY_RESET;
        else if (delay_we && delay_idx == CRC_CLS_W'(gi))
          thr_delay[gi] <= (delay_wdata > CRC_THR_MAX) ?
                           CRC_THR_MAX : delay_wdata;
      end
    end
  endgenerate

  // ==========================================================
  // Fill mask selection
  // ==========================================================
  wire [CRC_CLS_W-1:0] fill_cls = thread_class_assoc_reg[fill_tid]; // [RQ22]
  wire [CRC_MIDX_W-1:0] split_idx =
    {fill_cls[CRC_CLS_W-2:0], fill_is_code}; // [RQ7] [RQ20]
  wire [CRC_MIDX_W-1:0] sel_idx =
    split_en ? split_idx : fill_cls; // [RQ6]
  // Masks steer placement only; powered-down portions override them and
  // nothing here affects coherency.
  wire [CRC_MASK_W-1:0] next_way_mask =
    cap_mask[sel_idx] & cache_power_on; // [RQ3] [RQ4] [RQ17]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fill_valid <= 1'b0;
      fill_class <= CRC_CLASS_RESET;
      fill_way_mask <= CRC_MASK_RESET;
    end
    else
    begin
      fill_valid <= fill_req;
      fill_class <= fill_cls; // [RQ22]
      fill_way_mask <= next_way_mask; // [RQ4]
    end
  end

  // ==========================================================
  // Request rate limiter
  // ==========================================================
  // A class without a delay register is never throttled.
  function automatic logic [CRC_DELAY_W-1:0] cls_delay
    (input logic [CRC_CLS_W-1:0] c);
    if (c < CRC_THR_CLASSES)
      return thr_delay[c[2:0]];
    return CRC_DELAY_RESET; // [RQ15] [RQ16]
  endfunction

  wire [CRC_DELAY_W-1:0] d0 =
    thread_active[0] ? cls_delay(thread_class_assoc_reg[0]) : '0;
  wire [CRC_DELAY_W-1:0] d1 =
    thread_active[1] ? cls_delay(thread_class_assoc_reg[1]) : '0;
  wire [CRC_DELAY_W-1:0] next_core_delay = (d0 > d1) ? d0 : d1; // [RQ23]

  // The percentage delay becomes a duty cycle over a window of 100 cycles:
  // requests are granted only in the first (100 - delay) cycles.
  logic [CRC_RATE_W-1:0] rate_cnt;
  wire rate_wrap = rate_cnt == CRC_PERCENT[CRC_RATE_W-1:0] - 8'h01;
  wire [CRC_RATE_W-1:0] next_rate_cnt = rate_wrap ? 8'h00 : rate_cnt + 8'h01;
  wire [CRC_DELAY_W-1:0] open_len = CRC_PERCENT - core_delay;
  wire rate_open = {8'h00, rate_cnt} < open_len;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rate_cnt <= 8'h00;
      core_delay <= CRC_DELAY_RESET;
      core_req_grant <= 1'b0;
    end
    else
    begin
      rate_cnt <= next_rate_cnt;
      core_delay <= next_core_delay;
      core_req_grant <= core_req_valid && rate_open; // [RQ9]
    end
  end

  // ==========================================================
  // Identification query
  // ==========================================================
  wire q_feat = query_leaf == CRC_LEAF_FEAT && query_subleaf == CRC_SUB_ZERO;
  wire q_res0 = query_leaf == CRC_LEAF_RES && query_subleaf == CRC_SUB_ZERO;
  wire q_thr = query_leaf == CRC_LEAF_RES && query_subleaf == CRC_SUB_THR;
  wire [31:0] next_a = q_thr ? {20'h00000, CRC_THR_MAX_M1} : 32'h0; // [RQ12]
  wire [31:0] next_b = q_feat ? 32'h1 << CRC_FEAT_FLAG_BIT : // [RQ10]
                       q_res0 ? 32'h1 << CRC_THR_RES_BIT : 32'h0; // [RQ11]
  wire [31:0] next_c =
    q_thr ? {29'h0, CRC_THR_LINEAR, 2'b00} : 32'h0; // [RQ13]
  wire [31:0] next_d = q_thr ? {16'h0000, CRC_THR_CLS_M1} : 32'h0; // [RQ14]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      query_valid <= 1'b0;
      result_word_a <= 32'h0;
      result_word_b <= 32'h0;
      result_word_c <= 32'h0;
      result_word_d <= 32'h0;
    end
    else
    begin
      query_valid <= query_req;
      result_word_a <= next_a;
      result_word_b <= next_b;
      result_word_c <= next_c;
      result_word_d <= next_d;
    end
  end

  // ==========================================================
  // Readback
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      code_data_split <= 1'b0;
      class_rd0 <= CRC_CLASS_RESET;
      class_rd1 <= CRC_CLASS_RESET;
    end
    else
    begin
      code_data_split <= split_en;
      class_rd0 <= thread_class_assoc_reg[0];
      class_rd1 <= thread_class_assoc_reg[1];
    end
  end

endmodule

// File: dv/crc_checker.sv
`timescale 1ns/1ps
module crc_checker
  import crc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic assoc_we,
  input wire logic fill_req,
  input wire logic query_req,
  input wire logic [31:0] query_leaf,
  input wire logic [31:0] query_subleaf,
  input wire logic core_req_valid,
  input wire logic [CRC_CLS_W-1:0] class_rd0,
  input wire logic [CRC_CLS_W-1:0] class_rd1,
  input wire logic fill_valid,
  input wire logic core_req_grant,
  input wire logic query_valid,
  input wire logic [31:0] result_word_a,
  input wire logic [31:0] result_word_b,
  input wire logic [31:0] result_word_c,
  input wire logic [31:0] result_word_d
);
  // ==========================================================
  // Query decode and properties
  wire logic q_res = query_req && query_leaf == CRC_LEAF_RES;
  wire logic q_thr = q_res && query_subleaf == CRC_SUB_THR;
  wire logic q_feat = query_req && query_leaf == CRC_LEAF_FEAT
    && query_subleaf == CRC_SUB_ZERO;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_fill_answer: assert property (fill_req |=> fill_valid)
    else $error("fill request got no answer");
  chk_feat_flag: assert property (
    q_feat |=> query_valid && result_word_b == 32'h00008000)
    else $error("feature leaf word b wrong");
  chk_res_flag: assert property (
    q_res && query_subleaf == CRC_SUB_ZERO |=> result_word_b == 32'h8)
    else $error("resource leaf word b wrong");
  chk_thr_max: assert property (q_thr |=> result_word_a == 32'h59)
    else $error("throttle max word a wrong");
  chk_thr_linear: assert property (q_thr |=> result_word_c == 32'h4)
    else $error("throttle linear word c wrong");
  chk_thr_classes: assert property (q_thr |=> result_word_d == 32'h7)
    else $error("throttle class count wrong");
  chk_grant_cause: assert property (
    !core_req_valid |=> !core_req_grant)
    else $error("grant without a request");
  // Idle and management entry have no ports, so only a write may move it.
  chk_class_hold: assert property (
    !assoc_we [*3] |=> $stable(class_rd0) && $stable(class_rd1))
    else $error("class changed without a write");
  cover property (fill_valid);
  cover property (core_req_grant);
  cover property (q_thr);
endmodule
bind crc_top crc_checker u_chk (.clk(clk), .reset_n(reset_n),
  .assoc_we(assoc_we), .fill_req(fill_req), .query_req(query_req),
  .query_leaf(query_leaf), .query_subleaf(query_subleaf),
  .core_req_valid(core_req_valid), .class_rd0(class_rd0),
  .class_rd1(class_rd1), .fill_valid(fill_valid),
  .core_req_grant(core_req_grant), .query_valid(query_valid),
  .result_word_a(result_word_a), .result_word_b(result_word_b),
  .result_word_c(result_word_c), .result_word_d(result_word_d));

// File: dv/crc_core_model.sv
`timescale 1ns/1ps
module crc_core_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic want,
  input wire logic core_req_grant,
  output logic core_req_valid,
  output int grants
);
  // The core offers traffic as a level and retries every refused cycle.
  assign core_req_valid = want;
  always_ff @(posedge clk)
    grants <= reset_n ? grants + int'(core_req_grant) : 0;
endmodule

// File: dv/crc_top_test.sv
`timescale 1ns/1ps
module crc_top_test;
  import crc_pkg::*;
  logic clk = '0, reset_n = '0, assoc_we = '0, mask_we = '0, delay_we = '0;
  logic split_we = '0, assoc_tid = '0, split_wdata = '0, fill_req = '0;
  logic fill_tid = '0, fill_is_code = '0, query_req = '0, want = '0;
  logic [3:0] assoc_wdata = '0, mask_idx = '0, delay_idx = '0;
  logic [15:0] mask_wdata = '0, delay_wdata = '0, cache_power_on = 16'hffff;
  logic [1:0] thread_active = 2'h3;
  logic [31:0] query_leaf = '0, query_subleaf = '0;
  logic core_req_valid, code_data_split, fill_valid, core_req_grant;
  logic query_valid;
  logic [3:0] class_rd0, class_rd1, fill_class;
  logic [15:0] fill_way_mask, core_delay;
  logic [31:0] result_word_a, result_word_b, result_word_c, result_word_d;
  int mismatches = 0, check_count = 0, cycles = 0, grants, g0;
  crc_top DUT (.clk(clk), .reset_n(reset_n), .assoc_we(assoc_we),
    .assoc_tid(assoc_tid), .assoc_wdata(assoc_wdata), .mask_we(mask_we),
    .mask_idx(mask_idx), .mask_wdata(mask_wdata), .delay_we(delay_we),
    .delay_idx(delay_idx), .delay_wdata(delay_wdata), .split_we(split_we),
    .split_wdata(split_wdata), .thread_active(thread_active),
    .cache_power_on(cache_power_on), .fill_req(fill_req),
    .fill_tid(fill_tid), .fill_is_code(fill_is_code),
    .core_req_valid(core_req_valid), .query_req(query_req),
    .query_leaf(query_leaf), .query_subleaf(query_subleaf),
    .code_data_split(code_data_split), .class_rd0(class_rd0),
    .class_rd1(class_rd1), .fill_valid(fill_valid), .fill_class(fill_class),
    .fill_way_mask(fill_way_mask), .core_delay(core_delay),
    .core_req_grant(core_req_grant), .query_valid(query_valid),
    .result_word_a(result_word_a), .result_word_b(result_word_b),
    .result_word_c(result_word_c), .result_word_d(result_word_d));
  crc_core_model u_core (.clk(clk), .reset_n(reset_n), .want(want),
    .core_req_grant(core_req_grant), .core_req_valid(core_req_valid),
    .grants(grants));
  // ==========================================================
  // Clock, watchdog and shared tasks
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Wide enough for two result words side by side.
  task automatic check(input logic [63:0] seen, exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Kind 0 class, 1 mask, 2 delay, 3 split; waits out the readback lag.
  task automatic cfg(input int k, input logic [3:0] i, input logic [15:0] d);
    {assoc_we, mask_we, delay_we, split_we} = 4'h8 >> k;
    {assoc_tid, assoc_wdata, split_wdata} = {i[0], d[3:0], d[0]};
    {mask_idx, delay_idx, mask_wdata, delay_wdata} = {i, i, d, d};
    @(negedge clk);
    {assoc_we, mask_we, delay_we, split_we} = '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic fill(input logic t, c, input logic [3:0] ec,
    input logic [15:0] em);
    {fill_req, fill_tid, fill_is_code} = {1'b1, t, c};
    @(negedge clk);
    fill_req = 1'b0;
    check(fill_valid, 1'h1, "fill_valid");
    check(fill_class, ec, "fill_class");
    check(fill_way_mask, em, "fill_way_mask");
  endtask
  task automatic query(input logic [7:0] l, s, input logic [31:0] a, b, c, d);
    {query_req, query_leaf, query_subleaf} = {1'b1, 24'h0, l, 24'h0, s};
    @(negedge clk);
    query_req = 1'b0;
    check(query_valid, 1'h1, "query_valid");
    check({result_word_a, result_word_b}, {a, b}, "words_ab");
    check({result_word_c, result_word_d}, {c, d}, "words_cd");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check({code_data_split, class_rd0, class_rd1}, '0, "reset");
    fill(1'b0, 1'b1, 4'h0, 16'hffff);
  endtask
  task automatic t_query();
    query(8'h07, 8'h00, '0, 32'h8000, '0, '0);
    query(8'h10, 8'h00, '0, 32'h8, '0, '0);
    query(8'h10, 8'h03, 32'h59, '0, 32'h4, 32'h7);
  endtask
  task automatic t_masks();
    cfg(1, 4'h5, 16'h00f0);
    cfg(1, 4'h4, 16'h0f00);
    cfg(0, 4'h0, 16'h5);
    fill(1'b0, 1'b0, 4'h5, 16'h00f0);
    fill(1'b0, 1'b1, 4'h5, 16'h00f0);
    cfg(0, 4'h1, 16'h2);
    cfg(3, 4'h0, 16'h1);
    check(code_data_split, 1'h1, "split");
    fill(1'b1, 1'b0, 4'h2, 16'h0f00);
    fill(1'b1, 1'b1, 4'h2, 16'h00f0);
    cache_power_on = 16'h00ff;
    fill(1'b1, 1'b0, 4'h2, 16'h0000);
    cache_power_on = 16'hffff;
    fill(1'b1, 1'b0, 4'h2, 16'h0f00);
  endtask
  task automatic t_delay();
    cfg(2, 4'h2, 16'h0028);
    cfg(2, 4'h9, 16'h0046);
    cfg(0, 4'h0, 16'h9);
    check(core_delay, 16'h0028, "core_delay");
    want = 1'b1;
    repeat (2) @(negedge clk);
    g0 = grants;
    repeat (100) @(negedge clk);
    check(grants - g0, 32'h3c, "grants");
    want = 1'b0;
    thread_active = 2'h1;
    cfg(2, 4'h0, 16'h0014);
    cfg(0, 4'h0, 16'h0);
    check(core_delay, 16'h0014, "core_delay");
    thread_active = 2'h3;
  endtask
  task automatic t_hold();
    cfg(0, 4'h0, 16'hf);
    check(class_rd0, 4'hf, "class_rd0");
    cfg(0, 4'h0, 16'h0);
    thread_active = 2'h0;
    repeat (50) @(negedge clk);
    thread_active = 2'h3;
    check({class_rd0, class_rd1}, 8'h02, "classes");
    fill(1'b1, 1'b1, 4'h2, 16'h00f0);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_query();
    t_masks();
    t_delay();
    t_hold();
    print_verdict();
  end
endmodule
